// ---- design/ssa_pkg.sv ----
package ssa_pkg;

    // One FIFO slot: valid, parity error, character
    typedef struct packed {
        logic       vld;
        logic       perr;
        logic [7:0] dat;
    } ssa_ent_s;

    // Pins sampled into the clock domain, kept together
    typedef struct packed {
        logic       e;
        logic       cs;
        logic       rs;
        logic       rw;
        logic [7:0] d;
        logic       txc;
        logic       rxc;
        logic       rxd;
        logic       cts;
        logic       dcd_n;
    } ssa_pins_s;

    // Receiver character framing states
    typedef enum {RX_HUNT, RX_SECOND, RX_SYNCED} ssa_rx_e;

    localparam int unsigned FIFO_DEPTH = 3;

    // Control 1 fields
    localparam int unsigned CR1_RX_RST  = 0;
    localparam int unsigned CR1_TX_RST  = 1;
    localparam int unsigned CR1_CLR_SYN = 3;
    localparam int unsigned CR1_AC_LO   = 6;
    localparam logic [7:0]  CR1_RESET   = 8'h03;

    // Target of a write to the second location
    localparam logic [1:0] AC_CR2  = 2'h0;
    localparam logic [1:0] AC_CR3  = 2'h1;
    localparam logic [1:0] AC_SYNC = 2'h2;
    localparam logic [1:0] AC_TXD  = 2'h3;

    // Control 2 fields
    localparam int unsigned CR2_TWO_BYTE = 0;
    localparam int unsigned CR2_CLR_UF   = 1;
    localparam int unsigned CR2_SYNC_UF  = 2;
    localparam int unsigned CR2_WL8      = 3;
    localparam int unsigned CR2_PAR_EN   = 4;
    localparam int unsigned CR2_PAR_ODD  = 5;

    // Control 3 fields
    localparam int unsigned CR3_EXT_SYNC = 0;
    localparam int unsigned CR3_ONE_SYNC = 1;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MARK_FILL  = 8'hFF;
    localparam logic [8:0] SR_ONES    = 9'h1FF;
    localparam logic [3:0] LEN_FULL   = 4'h9;

endpackage

// ---- design/ssa_top.sv ----
`timescale 1ns/10ps
// Operation
// R1 - Two locations front seven internal registers
// R2 - Writes enter three-slot tx FIFO, advance
// R3 - Space flag shows tx FIFO input free
// R4 - FIFO moves paced by enable strobe
// R5 - One-byte and two-byte transfer modes
// R6 - Last slot loads during last half-bit
// R7 - LSB first; bits above length ignored
// R8 - Optional even or odd parity appended
// R9 - Underflow sends ones or sync code
// R10 - Underflow pulse lasts one clock-high period
// R11 - Pulse aligns with last half-bit before fill
// R12 - Underflow status sticky until software clears
// R13 - Clear-to-send holds tx, keeps FIFO
// R14 - Separate transmit and receive clocks
// R15 - External sync via carrier detect
// R16 - Single sync: one match starts data
// R17 - Two sync: two successive matches
// R18 - Parity error travels with character
// R19 - Status shows data available, parity error
// R20 - Reset latches transmitter and receiver reset
// R21 - Software programs setup before releasing reset
// R22 - Tx starts first clock-high, fill if empty
// R23 - Data available per transfer mode slots
// R24 - Missed second sync resumes bit search
// R25 - FIFO read clears data available flag
// R26 - One position per strobe, into empties
module ssa_top
    import ssa_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       e_i,
    input  wire logic       cs_i,
    input  wire logic       rs_i,
    input  wire logic       rw_i,
    input  wire logic [7:0] d_i,
    output logic      [7:0] d_o,
    output logic            d_oe_o,
    input  wire logic       tx_clk_i,
    input  wire logic       rx_clk_i,
    input  wire logic       rx_data_i,
    input  wire logic       cts_i,
    input  wire logic       dcd_n_i,
    output logic            tx_data_o,
    output logic            tx_underflow_output_o,
    output logic            sync_match_terminal_ready_o,
    output logic            tx_fifo_space_flag_o,
    output logic            rx_data_available_flag_o
);

    // Even parity of the active data bits, inverted for odd
    function automatic logic par_of(input logic [7:0] d,
                                    input logic wl8,
                                    input logic odd);
        par_of = ^(wl8 ? d : {1'b0, d[6:0]}) ^ odd;
    endfunction

    // Data bits with unused top bit dropped
    function automatic logic [7:0] trim(input logic [7:0] d,
                                        input logic wl8);
        trim = wl8 ? d : {1'b0, d[6:0]};
    endfunction

    logic [1:0] rst_q;            // Reset release pipeline
    logic       rst_n;            // Synchronised reset
    ssa_pins_s  pin_q1;           // First stage, read only by q2
    ssa_pins_s  pin_q2;           // Safe sampled pins
    ssa_pins_s  pin_q3;           // Previous, for edges
    logic [7:0] cr1;              // Control 1
    logic [7:0] cr2;              // Control 2
    logic [7:0] cr3;              // Control 3
    logic [7:0] sync_code;        // Sync code
    ssa_ent_s   txf [FIFO_DEPTH]; // Tx FIFO, slot 2 is output
    ssa_ent_s   next_txf [FIFO_DEPTH];
    ssa_ent_s   rxf [FIFO_DEPTH]; // Rx FIFO, slot 2 is output
    ssa_ent_s   next_rxf [FIFO_DEPTH];
    logic [8:0] tx_sr;            // Frame being sent
    logic [8:0] tx_nxt;           // Frame loaded at last half-bit
    logic       tx_pend;          // Next frame waiting for fall
    logic       tx_act;           // Transmitter running
    logic [3:0] tx_cnt;           // Bit index in frame
    logic       uf_flag;          // Sticky underflow status
    logic [8:0] rx_sr;            // Receive shift register
    logic [8:0] next_rx_sr;
    ssa_rx_e    rx_st;            // Framing state
    logic [3:0] rx_cnt;           // Bits since boundary

    // Reset release, asserted asynchronously
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Two-stage pin synchroniser plus edge history
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_q1 <= '0;
            pin_q2 <= '0;
            pin_q3 <= '0;
        end else begin
            pin_q1 <= {e_i, cs_i, rs_i, rw_i, d_i, tx_clk_i,
                       rx_clk_i, rx_data_i, cts_i, dcd_n_i};
            pin_q2 <= pin_q1;
            pin_q3 <= pin_q2;
        end
    end

    // Strobe and serial clock edges
    wire e_rise   = pin_q2.e & ~pin_q3.e;
    wire e_fall   = ~pin_q2.e & pin_q3.e;         // see R4
    wire txc_rise = pin_q2.txc & ~pin_q3.txc;     // see R14
    wire txc_fall = ~pin_q2.txc & pin_q3.txc;
    wire rxc_rise = pin_q2.rxc & ~pin_q3.rxc;     // see R14
    wire wr       = e_rise & pin_q2.cs & ~pin_q2.rw;
    wire rd       = e_rise & pin_q2.cs & pin_q2.rw;
    wire [1:0] ac = cr1[CR1_AC_LO +: 2];
    wire wr2      = wr & pin_q2.rs;
    wire tx_wr    = wr2 & (ac == AC_TXD);
    wire clr_uf   = wr2 & (ac == AC_CR2) & pin_q2.d[CR2_CLR_UF];
    wire rx_pop   = rd & pin_q2.rs;

    // Decoded configuration
    wire two_byte = cr2[CR2_TWO_BYTE];
    wire wl8      = cr2[CR2_WL8];
    wire par_en   = cr2[CR2_PAR_EN];
    wire par_odd  = cr2[CR2_PAR_ODD];
    wire syn_uf   = cr2[CR2_SYNC_UF];
    wire ext_sync = cr3[CR3_EXT_SYNC];
    wire one_sync = cr3[CR3_ONE_SYNC];
    wire tx_rst   = cr1[CR1_TX_RST];
    wire rx_rst   = cr1[CR1_RX_RST];
    wire clr_sync = cr1[CR1_CLR_SYN];
    wire cts      = pin_q2.cts;
    wire tx_hold  = tx_rst | cts;                 // see R13
    wire [3:0] len = (wl8 ? 4'h8 : 4'h7) + {3'h0, par_en};
    wire [7:0] sync_t = trim(sync_code, wl8);

    // Register writes; reset leaves both sections held
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cr1       <= CR1_RESET;               // see R20
            cr2       <= CTRL_RESET;
            cr3       <= CTRL_RESET;
            sync_code <= CTRL_RESET;
        end else if (wr) begin
            if (!pin_q2.rs) begin
                cr1 <= pin_q2.d;                  // see R1
            end else begin
                case (ac)                         // see R1
                    AC_CR2:  cr2 <= pin_q2.d;
                    AC_CR3:  cr3 <= pin_q2.d;
                    AC_SYNC: sync_code <= pin_q2.d;
                    default: ;
                endcase
            end
        end
    end

    // Transmitter takes a frame at rise of the last bit
    wire tx_last = ~tx_act | (tx_cnt == len - 4'h1);
    wire tx_load = txc_rise & ~tx_hold & tx_last; // see R6
    wire tx_uf   = tx_load & ~txf[2].vld;         // see R9

    // Frame: data LSB first, parity right above it
    function automatic logic [8:0] mk_frame(input logic [7:0] d);
        logic [8:0] f;
        f = {1'b0, trim(d, wl8)};                 // see R7
        if (par_en) begin
            f[len - 4'h1] = par_of(d, wl8, par_odd); // see R8
        end
        mk_frame = f;
    endfunction

    // Tx FIFO: pop, then strobe shifts, then write
    always_comb begin
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            next_txf[i] = txf[i];
        end
        if (tx_load & txf[2].vld) begin
            next_txf[2].vld = 1'b0;
        end
        if (e_fall) begin
            // Top first, so each moves a single slot
            for (int i = FIFO_DEPTH - 1; i > 0; i--) begin
                if (!next_txf[i].vld && next_txf[i-1].vld) begin
                    next_txf[i]       = next_txf[i-1]; // see R26
                    next_txf[i-1].vld = 1'b0;
                end
            end
        end
        if (tx_wr && !next_txf[0].vld) begin
            next_txf[0] = {1'b1, 1'b0, pin_q2.d}; // see R2
        end
        if (tx_rst) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                next_txf[i].vld = 1'b0;
            end
        end
    end

    // Tx FIFO storage; clear-to-send leaves it alone
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                txf[i] <= '0;
            end
        end else begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                txf[i] <= next_txf[i];            // see R13
            end
        end
    end

    // Serial transmitter, bit changes on clock fall
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_sr     <= '0;
            tx_nxt    <= '0;
            tx_pend   <= 1'b0;
            tx_act    <= 1'b0;
            tx_cnt    <= 4'h0;
            tx_data_o <= 1'b1;
            tx_underflow_output_o <= 1'b0;
        end else if (tx_hold) begin
            // Idle mark while held
            tx_pend   <= 1'b0;
            tx_act    <= 1'b0;
            tx_cnt    <= 4'h0;
            tx_data_o <= 1'b1;                    // see R13
            tx_underflow_output_o <= 1'b0;
        end else begin
            if (tx_load) begin
                // First rise after release counts as a boundary
                tx_pend <= 1'b1;                  // see R22
                tx_nxt  <= txf[2].vld ? mk_frame(txf[2].dat)
                         : mk_frame(syn_uf ? sync_code : MARK_FILL);
                tx_underflow_output_o <= tx_uf & syn_uf; // see R11
            end else if (txc_fall) begin
                tx_underflow_output_o <= 1'b0;    // see R10
                if (tx_pend) begin
                    tx_sr     <= tx_nxt;
                    tx_cnt    <= 4'h0;
                    tx_data_o <= tx_nxt[0];       // see R7
                    tx_act    <= 1'b1;
                    tx_pend   <= 1'b0;
                end else if (tx_act) begin
                    tx_cnt    <= tx_cnt + 4'h1;
                    tx_data_o <= tx_sr[tx_cnt + 4'h1];
                end
            end
        end
    end

    // Sticky underflow; a new event beats the clear
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            uf_flag <= 1'b0;
        end else if (tx_uf) begin
            uf_flag <= 1'b1;                      // see R12
        end else if (clr_uf) begin
            uf_flag <= 1'b0;
        end
    end

    // Received character ends at the newest bit
    always_comb begin
        next_rx_sr = {pin_q2.rxd, rx_sr[8:1]};
    end
    wire [8:0] rx_chr  = next_rx_sr >> (LEN_FULL - len);
    wire [7:0] rx_dat  = trim(rx_chr[7:0], wl8);
    wire       rx_par  = rx_chr[len - 4'h1];
    wire       rx_perr = par_en & (rx_par != par_of(rx_dat, wl8, par_odd));
    wire       rx_match = rx_dat == sync_t;
    wire       rx_halt = rx_rst | clr_sync;
    wire       rx_end  = rx_cnt == len - 4'h1;
    wire       rx_push = rxc_rise & ~rx_halt & (rx_st == RX_SYNCED) & rx_end;

    // Rx shift register fills with ones on reset
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_sr <= SR_ONES;
        end else if (rx_rst) begin
            rx_sr <= SR_ONES;
        end else if (rxc_rise) begin
            rx_sr <= next_rx_sr;
        end
    end

    // Character framing search
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_st  <= RX_HUNT;
            rx_cnt <= 4'h0;
            sync_match_terminal_ready_o <= 1'b0;
        end else if (rx_halt) begin
            rx_st  <= RX_HUNT;
            rx_cnt <= 4'h0;
            sync_match_terminal_ready_o <= 1'b0;
        end else begin
            sync_match_terminal_ready_o <= 1'b0;
            if (rxc_rise) begin
                rx_cnt <= rx_end ? 4'h0 : rx_cnt + 4'h1;
                case (rx_st)
                    RX_HUNT: begin
                        rx_cnt <= 4'h0;
                        if (ext_sync) begin
                            if (!pin_q2.dcd_n) begin
                                rx_st <= RX_SYNCED; // see R15
                            end
                        end else if (rx_match) begin
                            sync_match_terminal_ready_o <= 1'b1;
                            rx_st <= one_sync ? RX_SYNCED  // see R16
                                              : RX_SECOND;
                        end
                    end
                    RX_SECOND: begin
                        if (rx_end) begin
                            // Miss falls back to bitwise search
                            rx_st <= rx_match ? RX_SYNCED // see R17
                                              : RX_HUNT;  // see R24
                            sync_match_terminal_ready_o <= rx_match;
                        end
                    end
                    RX_SYNCED: begin
                        if (ext_sync && pin_q2.dcd_n) begin
                            rx_st  <= RX_HUNT;
                            rx_cnt <= 4'h0;
                        end
                    end
                    default: rx_st <= RX_HUNT;
                endcase
            end
        end
    end

    // Rx FIFO: read, then strobe shifts, then push
    always_comb begin
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            next_rxf[i] = rxf[i];
        end
        if (rx_pop) begin
            next_rxf[2].vld = 1'b0;               // see R25
        end
        if (e_fall) begin
            for (int i = FIFO_DEPTH - 1; i > 0; i--) begin
                if (!next_rxf[i].vld && next_rxf[i-1].vld) begin
                    next_rxf[i]       = next_rxf[i-1]; // see R26
                    next_rxf[i-1].vld = 1'b0;
                end
            end
        end
        if (rx_push) begin
            // Overrun simply replaces the input slot
            next_rxf[0] = {1'b1, rx_perr, rx_dat}; // see R18
        end
        if (rx_rst) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                next_rxf[i].vld = 1'b0;
            end
        end
    end

    // Rx FIFO storage
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                rxf[i] <= '0;
            end
        end else begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                rxf[i] <= next_rxf[i];
            end
        end
    end

    // Flags; space is blocked by reset and, unless external sync is set, CTS
    wire space = (two_byte ? ~txf[0].vld & ~txf[1].vld
                           : ~txf[0].vld)         // see R5
               & ~tx_rst & ~(cts & ~ext_sync);    // see R3
    wire rx_data_available_flag   = two_byte ? rxf[1].vld & rxf[2].vld
                          : rxf[2].vld;           // see R23
    wire [7:0] status = {1'b0, rxf[2].perr & rx_data_available_flag, 1'b0, uf_flag,
                         cts, pin_q2.dcd_n, space, rx_data_available_flag}; // see R19

    // Flag outputs, one cycle behind the FIFOs
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_fifo_space_flag_o     <= 1'b0;
            rx_data_available_flag_o <= 1'b0;
        end else begin
            tx_fifo_space_flag_o     <= space;
            rx_data_available_flag_o <= rx_data_available_flag;
        end
    end

    // Read data captured at strobe rise, driven while strobe high
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            d_o    <= 8'h00;
            d_oe_o <= 1'b0;
        end else begin
            d_oe_o <= pin_q2.e & pin_q2.cs & pin_q2.rw;
            if (rd) begin
                d_o <= pin_q2.rs ? rxf[2].dat : status; // see R1
            end
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_tx_last;
        txc_rise && tx_act && !tx_hold && tx_cnt == len - 4'h1;
    endsequence
    sequence s_uf_rise;
        tx_uf && syn_uf;
    endsequence

    chk_load_last: assert property (s_tx_last |=> tx_pend) // see R6
        else $error("frame not loaded at last half-bit");
    chk_tuf_start: assert property (s_uf_rise |=> tx_underflow_output_o)
        else $error("underflow pulse missing"); // see R11
    chk_tuf_end: assert property (
        tx_underflow_output_o && txc_fall |=> !tx_underflow_output_o)
        else $error("underflow pulse too long"); // see R10
    chk_uf_sticky: assert property (uf_flag && !clr_uf |=> uf_flag)
        else $error("underflow status lost"); // see R12
    chk_fifo_step: assert property (
        e_fall && !tx_rst && !tx_load && !txf[2].vld && txf[1].vld
        |=> txf[2].dat == $past(txf[1].dat) && txf[2].vld)
        else $error("tx FIFO did not advance"); // see R26
    chk_cts_hold: assert property (
        cts && !tx_rst && txf[2].vld |=> txf[2].vld && tx_data_o)
        else $error("clear-to-send lost data"); // see R13
    chk_rx_pop: assert property (rx_pop && !rx_rst |=> !rxf[2].vld)
        else $error("read did not empty output slot"); // see R25
    chk_two_sync: assert property (
        rx_st == RX_HUNT && rxc_rise && rx_match && !rx_halt
        && !ext_sync && !one_sync |=> rx_st == RX_SECOND)
        else $error("first sync not followed up"); // see R17
    chk_reset_latch: assert property ($rose(rst_q[1]) |-> cr1 == CR1_RESET)
        else $error("sections not held after reset"); // see R20

endmodule

// ---- design/ssa_unused_placeholder_none.sv ----
`timescale 1ns/10ps

// ---- tb/ssa_peer_model.sv ----
`timescale 1ns/10ps
// Serial peer: makes the link clocks and loops the line back
module ssa_peer_model (
    input  wire logic        run_i,
    input  wire logic        tx_data_i,
    output logic             tx_clk_o,
    output logic             rx_clk_o,
    output logic             rx_data_o,
    output logic [23:0]      tx_hist_o
);
    // Link clock, 400 ns, parked low while stopped
    initial begin
        tx_clk_o = 1'b0;
        #7;
        forever begin
            #200;
            tx_clk_o = run_i ? ~tx_clk_o : 1'b0;
        end
    end

    // Receive clock is its own pin, fed from the same source
    assign rx_clk_o = tx_clk_o;

    // Loopback, so the receiver hunts on what we send
    assign rx_data_o = tx_data_i;

    // Newest bit enters at the top; LSB-first bytes read naturally
    initial tx_hist_o = 24'h000000;
    always @(posedge tx_clk_o) begin
        tx_hist_o <= {tx_data_i, tx_hist_o[23:1]};
    end
endmodule

// ---- tb/sync_serial_data_adapter_tb_top.sv ----
`timescale 1ns/10ps
module sync_serial_data_adapter_tb_top import ssa_pkg::*; ;
    logic        clk = 1'b0;   // System clock
    logic        arst_n;       // Reset, active low
    logic        e = 1'b0;     // Bus enable strobe
    logic        cs, rs, rw;   // Bus select lines
    logic [7:0]  d, d_o;       // Bus data in and out
    logic        doe, txd;     // Bus drive, serial out
    logic        tx_underflow_output, sm;      // Underflow and sync pulses
    logic        space, rx_data_available_flag;   // Status flags
    logic        cts, run;     // Clear-to-send, peer enable
    logic        txc, rxc, rxd; // Link clocks and line
    logic [23:0] hist;         // Recent transmitted bits
    logic [7:0]  q;            // Read result
    int          fails = 0;    // Mismatch count
    int          checked = 0;  // Comparison count
    int          ecnt = 0;     // Enable phase, 20 cycles
    int          n;            // Bounded wait counter
    logic        sm_seen = 1'b0; // Sync match pulse caught

    ssa_top u_dut (
        .ref_clk_i(clk), .arst_n_i(arst_n), .e_i(e), .cs_i(cs),
        .rs_i(rs), .rw_i(rw), .d_i(d), .d_o(d_o), .d_oe_o(doe),
        .tx_clk_i(txc), .rx_clk_i(rxc), .rx_data_i(rxd),
        .cts_i(cts), .dcd_n_i(1'b1), .tx_data_o(txd),
        .tx_underflow_output_o(tx_underflow_output),
        .sync_match_terminal_ready_o(sm),
        .tx_fifo_space_flag_o(space),
        .rx_data_available_flag_o(rx_data_available_flag)
    );

    ssa_peer_model u_peer (
        .run_i(run), .tx_data_i(txd), .tx_clk_o(txc),
        .rx_clk_o(rxc), .rx_data_o(rxd), .tx_hist_o(hist)
    );

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    // Free-running strobe: FIFOs only move on its pulses
    always @(negedge clk) begin
        ecnt <= (ecnt == 19) ? 0 : ecnt + 1;
        e <= (ecnt == 19) || (ecnt < 9);
    end

    // Catch the one-cycle sync match pulse
    always @(posedge clk) begin
        if (sm === 1'b1) begin
            sm_seen <= 1'b1;
        end
    end

    task automatic chk(input string what, input logic [7:0] got,
                       input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Wait for a given strobe phase
    task automatic tick(input int ph);
        do @(negedge clk); while (ecnt != ph);
    endtask

    // One bus cycle, held across the whole strobe pulse
    task automatic bus(input logic s, input logic r,
                       input logic [7:0] wd, output logic [7:0] rd);
        tick(15);
        cs = 1'b1;
        rs = s;
        rw = r;
        d = wd;
        tick(9);
        rd = d_o;
        tick(12);
        cs = 1'b0;
        rw = 1'b1;
    endtask

    task automatic wr(input logic s, input logic [7:0] wd);
        logic [7:0] junk;
        bus(s, 1'b0, wd, junk);
    endtask

    // Point the second location, resets still held, then write
    task automatic wreg(input logic [1:0] ac, input logic [7:0] v);
        wr(1'b0, {ac, 6'h03});
        wr(1'b1, v);
    endtask

    task automatic report_and_stop;
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog, well beyond the roughly 1300 cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end

    initial begin
        arst_n = 1'b0;
        cs = 1'b0;
        rs = 1'b0;
        rw = 1'b1;
        d = 8'h00;
        cts = 1'b1;
        run = 1'b0;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("tx idle", {7'h00, txd}, 8'h01);
        chk("rda idle", {7'h00, rx_data_available_flag}, 8'h00);
        chk("bus drive", {7'h00, doe}, 8'h00);
        // Setup first: 8-bit, sync fill, one-sync, code 16
        wreg(AC_CR2, 8'h0C);
        wreg(AC_CR3, 8'h02);
        wreg(AC_SYNC, 8'h16);
        wr(1'b0, {AC_TXD, 6'h00});
        // Preload the FIFO while clear-to-send holds off
        wr(1'b1, 8'h16);
        wr(1'b1, 8'h3C);
        wr(1'b1, 8'h81);
        chk("cts hold", {7'h00, txd}, 8'h01);
        chk("no sync", {7'h00, rx_data_available_flag}, 8'h00);
        run = 1'b1;
        cts = 1'b0;
        n = 0;
        while (hist !== 24'h813C16 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("tx byte 3", hist[23:16], 8'h81);
        chk("tx byte 2", hist[15:8], 8'h3C);
        chk("tx byte 1", hist[7:0], 8'h16);
        chk("sync match", {7'h00, sm_seen}, 8'h01);
        // Receiver drops the sync, then hands data over in order
        foreach (hist[i]) begin
            if (i == 0 || i == 8) begin
                n = 0;
                while (rx_data_available_flag !== 1'b1 && n < 400) begin
                    @(negedge clk);
                    n++;
                end
                bus(1'b1, 1'b1, 8'h00, q);
                chk("rx data", q, (i == 8) ? 8'h3C : 8'h81);
            end
        end
        // Fill after the last byte brings an underflow pulse
        // Let any pulse in progress end, so a whole one is timed
        n = 0;
        while (tx_underflow_output !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (tx_underflow_output !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (tx_underflow_output === 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk("uf width", n[7:0], 8'h04);
        chk("space", {7'h00, space}, 8'h01);
        bus(1'b0, 1'b1, 8'h00, q);
        chk("uf set", {7'h00, q[4]}, 8'h01);
        // Stop the sender; the flag must outlast it
        cts = 1'b1;
        repeat (200) @(negedge clk);
        chk("cts idle", {7'h00, txd}, 8'h01);
        bus(1'b0, 1'b1, 8'h00, q);
        chk("uf sticky", {7'h00, q[4]}, 8'h01);
        wr(1'b0, {AC_CR2, 6'h00});
        wr(1'b1, 8'h0E);
        bus(1'b0, 1'b1, 8'h00, q);
        chk("uf clear", {7'h00, q[4]}, 8'h00);
        // Second pass: even parity, two-sync search, preloaded
        wreg(AC_CR2, 8'h1C);
        wreg(AC_CR3, 8'h00);
        wr(1'b0, {AC_TXD, 6'h00});
        wr(1'b1, 8'h16);
        wr(1'b1, 8'h16);
        wr(1'b1, 8'hA5);
        cts = 1'b0;
        // Parity bit follows each character on the line
        n = 0;
        while (hist !== 24'h52C5A2 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("par frame hi", hist[23:16], 8'h52);
        chk("par frame mid", hist[15:8], 8'hC5);
        chk("par frame lo", hist[7:0], 8'hA2);
        n = 0;
        while (rx_data_available_flag !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        bus(1'b0, 1'b1, 8'h00, q);
        chk("rx par ok", {1'b0, q[6], 5'h00, q[0]}, 8'h01);
        bus(1'b1, 1'b1, 8'h00, q);
        chk("two sync data", q, 8'hA5);
        report_and_stop();
    end
endmodule
